/* hdl/flash_iap_pkg.sv */
// Constants, register map and types of the program-memory update controller
`default_nettype none
package flash_iap_pkg;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int UNLOCK_TIME_NS = 4000;
  localparam int PROG_TIME_NS = 8000;
  localparam int READ_TIME_NS = 40;
  localparam int UNLOCK_CYCLES =
    (UNLOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYCLES = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_WORDS = 32;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] UNLOCK_LAST = CNT_W'(UNLOCK_CYCLES - 1);
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);
  localparam logic [CNT_W-1:0] READ_LAST = CNT_W'(READ_CYCLES - 1);
  localparam logic [CNT_W-1:0] CLEAR_LAST = CNT_W'(PAGE_WORDS - 1);
  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DATA0_LOW = 8'h00;
  localparam logic [7:0] OFS_DATA0_HIGH = 8'h04;
  localparam logic [7:0] OFS_DATA3_HIGH = 8'h1c;
  localparam logic [7:0] OFS_PROGRAM_CONTROL = 8'h20;
  localparam logic [7:0] OFS_CHIP_RESET_PATTERN = 8'h24;
  localparam logic [7:0] OFS_BUFFER_CLEAR_CONTROL = 8'h28;
  localparam logic [7:0] OFS_ADDRESS_LOW = 8'h2c;
  localparam logic [7:0] OFS_ADDRESS_HIGH = 8'h30;
  // ==========================================================================
  // Field positions and reset values
  localparam int BIT_ENABLED = 7;
  localparam int MODE_MSB = 6;
  localparam int MODE_LSB = 4;
  localparam int BIT_TRIGGER = 3;
  localparam int BIT_WRITE_INIT = 2;
  localparam int BIT_READ_EN = 1;
  localparam int BIT_READ_INIT = 0;
  localparam int BIT_BUF_CLEAR = 0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] ADDR_HIGH_RESET = 4'h0;
  localparam logic [4:0] LAST_WORD = 5'h1f;
  // ==========================================================================
  // Mode codes, unlock pattern, reset key
  localparam logic [2:0] MODE_WRITE = 3'h0;
  localparam logic [2:0] MODE_ERASE = 3'h1;
  localparam logic [2:0] MODE_READ = 3'h3;
  localparam logic [2:0] MODE_UNLOCK = 3'h6;
  localparam logic [7:0] KEY_D1_LOW = 8'h00;
  localparam logic [7:0] KEY_D2_LOW = 8'h0d;
  localparam logic [7:0] KEY_D3_LOW = 8'hc3;
  localparam logic [7:0] KEY_D1_HIGH = 8'h04;
  localparam logic [7:0] KEY_D2_HIGH = 8'h09;
  localparam logic [7:0] KEY_D3_HIGH = 8'h40;
  localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
  // ==========================================================================
  // Types
  typedef enum logic [2:0] {OP_IDLE, OP_ERASE, OP_WRITE, OP_READ, OP_CLEAR}
    op_state_t;
endpackage
`default_nettype wire

/* hdl/flash_iap_program_controller.sv */
// Program-memory update controller with APB register slave
// ============================================================================
// Summary of operation
// - Low data byte write only stores itself
// - DATA0 high byte write loads word when enabled, bumps address
// - Software cannot set enable; clearing disables
// - Hardware sets enable only on unlock success
// - Mode codes: write, erase, read, unlock
// - Trigger bit starts timer, cleared at expiry
// - Write initiate runs process, self clears
// - Reads need read enable set
// - Read initiate runs read, self clears
// - CPU stalled during running erase, write or read; not during buffer clear
// - Writing 55h resets whole chip
// - Buffer clear bit clears buffer, self clears
// - Upper buffer clear bits read zero
// - Address increment holds at last page word
// - Unlock pattern per register must match
// - Expiry clears trigger; bad pattern stays locked
// - Buffer is one page, cleared after write
`default_nettype none
module flash_iap_program_controller (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] flash_rdata,
  output logic flash_erase,
  output logic flash_program,
  output logic flash_read,
  output logic [11:0] flash_addr,
  output logic [15:0] flash_wdata,
  output logic cpu_stall,
  output logic chip_reset
);
  // ==========================================================================
  // State
  logic [7:0] data_low_reg [0:3];
  logic [7:0] data_high_reg [0:3];
  logic [15:0] buf_mem [0:flash_iap_pkg::PAGE_WORDS-1];
  logic [flash_iap_pkg::PAGE_WORDS-1:0] tag_reg;
  logic [7:0] address_low_reg;
  logic [3:0] address_high_reg;
  logic enabled_reg, trigger_reg, winit_reg, rden_reg, rinit_reg, bufclr_reg;
  logic [2:0] mode_reg;
  logic [7:0] reset_pattern_reg;
  logic [flash_iap_pkg::CNT_W-1:0] unlock_cnt_reg, op_cnt_reg;
  flash_iap_pkg::op_state_t op_state_reg, op_next;
  logic pready_reg, pslverr_reg, erase_reg, program_reg, read_reg;
  logic stall_reg, chip_reset_reg;
  logic [31:0] prdata_reg;
  logic [11:0] flash_addr_reg;
  logic [15:0] flash_wdata_reg;

  function automatic logic [11:0] next_word_addr(input logic [11:0] a);
    if (a[4:0] == flash_iap_pkg::LAST_WORD)
    begin
      return a;
    end
    return a + 12'h001;
  endfunction

  // ==========================================================================
  // APB decode
  wire logic setup = psel & ~penable;
  wire logic fire = psel & penable & pready_reg & ce;
  wire logic wr = fire & pwrite;
  wire logic aligned = (paddr[1:0] == 2'h0);
  wire logic is_data = aligned & (paddr <= flash_iap_pkg::OFS_DATA3_HIGH);
  wire logic [1:0] data_idx = paddr[4:3];
  wire logic data_hi = paddr[2];
  wire logic is_ctrl = (paddr == flash_iap_pkg::OFS_PROGRAM_CONTROL);
  wire logic is_rst = (paddr == flash_iap_pkg::OFS_CHIP_RESET_PATTERN);
  wire logic is_clr = (paddr == flash_iap_pkg::OFS_BUFFER_CLEAR_CONTROL);
  wire logic is_alo = (paddr == flash_iap_pkg::OFS_ADDRESS_LOW);
  wire logic is_ahi = (paddr == flash_iap_pkg::OFS_ADDRESS_HIGH);
  wire logic mapped = is_data | is_ctrl | is_rst | is_clr | is_alo | is_ahi;
  wire logic ctrl_wr = wr & is_ctrl;
  wire logic d0h_wr = wr & (paddr == flash_iap_pkg::OFS_DATA0_HIGH);
  wire logic idle = (op_state_reg == flash_iap_pkg::OP_IDLE);
  wire logic [7:0] ctrl_value = {enabled_reg, mode_reg, trigger_reg,
                                 winit_reg, rden_reg, rinit_reg};
  wire logic [7:0] data_value = data_hi ? data_high_reg[data_idx]
                                        : data_low_reg[data_idx];
  wire logic [7:0] rd_value =
    is_data ? data_value :
    is_ctrl ? ctrl_value :
    is_rst ? reset_pattern_reg :
    is_clr ? {7'h00, bufclr_reg} :
    is_alo ? address_low_reg :
    is_ahi ? {4'h0, address_high_reg} : 8'h00;
  wire logic [11:0] word_addr = {address_high_reg, address_low_reg};
  wire logic [11:0] inc_addr = next_word_addr(word_addr);

  // ==========================================================================
  // Unlock procedure
  wire logic pattern_ok =
    (data_low_reg[1] == flash_iap_pkg::KEY_D1_LOW) &
    (data_low_reg[2] == flash_iap_pkg::KEY_D2_LOW) &
    (data_low_reg[3] == flash_iap_pkg::KEY_D3_LOW) &
    (data_high_reg[1] == flash_iap_pkg::KEY_D1_HIGH) &
    (data_high_reg[2] == flash_iap_pkg::KEY_D2_HIGH) &
    (data_high_reg[3] == flash_iap_pkg::KEY_D3_HIGH);
  wire logic expire = trigger_reg &
                      (unlock_cnt_reg == flash_iap_pkg::UNLOCK_LAST);
  wire logic unlock_ok = expire & pattern_ok &
                         (mode_reg == flash_iap_pkg::MODE_UNLOCK);
  wire logic trig_start = ctrl_wr & pwdata[flash_iap_pkg::BIT_TRIGGER] &
                          ~trigger_reg;

  // ==========================================================================
  // Operation sequencing
  wire logic prog_mode = (mode_reg == flash_iap_pkg::MODE_WRITE) |
                         (mode_reg == flash_iap_pkg::MODE_ERASE);
  wire logic start_prog = idle & winit_reg & enabled_reg & prog_mode;
  wire logic start_read = idle & ~start_prog & rinit_reg & rden_reg &
                          (mode_reg == flash_iap_pkg::MODE_READ);
  wire logic start_clear = idle & ~start_prog & ~start_read & bufclr_reg;
  wire logic prog_done = ((op_state_reg == flash_iap_pkg::OP_ERASE) |
                          (op_state_reg == flash_iap_pkg::OP_WRITE)) &
                         (op_cnt_reg == flash_iap_pkg::PROG_LAST);
  wire logic read_done = (op_state_reg == flash_iap_pkg::OP_READ) &
                         (op_cnt_reg == flash_iap_pkg::READ_LAST);
  wire logic clear_done = (op_state_reg == flash_iap_pkg::OP_CLEAR) &
                          (op_cnt_reg == flash_iap_pkg::CLEAR_LAST);
  wire logic winit_clr = prog_done | (idle & winit_reg & ~start_prog);
  wire logic rinit_clr = read_done |
                         (idle & rinit_reg & ~start_prog & ~start_read);
  wire logic buf_wipe = clear_done |
                        ((op_state_reg == flash_iap_pkg::OP_WRITE) &
                         prog_done);
  wire logic buf_load = d0h_wr & enabled_reg & idle;
  wire logic [4:0] step = op_cnt_reg[4:0];
  wire logic step_in_page = (op_cnt_reg < flash_iap_pkg::CLEAR_LAST + 1'b1);
  wire logic prog_pulse = (op_state_reg == flash_iap_pkg::OP_WRITE) &
                          step_in_page & tag_reg[step];
  wire logic erase_pulse = (op_state_reg == flash_iap_pkg::OP_ERASE) &
                           (op_cnt_reg == '0);
  wire logic read_pulse = (op_state_reg == flash_iap_pkg::OP_READ) &
                          (op_cnt_reg == '0);

  // Software may only clear the enable bit; the unlock set wins
  wire logic enabled_next = unlock_ok ? 1'b1 :
    (ctrl_wr & ~pwdata[flash_iap_pkg::BIT_ENABLED]) ? 1'b0 :
    enabled_reg;
  wire logic trigger_next = ctrl_wr ? pwdata[flash_iap_pkg::BIT_TRIGGER] :
                            expire ? 1'b0 : trigger_reg;
  wire logic winit_next = ctrl_wr ? pwdata[flash_iap_pkg::BIT_WRITE_INIT] :
                          winit_clr ? 1'b0 : winit_reg;
  wire logic rinit_next = ctrl_wr ? pwdata[flash_iap_pkg::BIT_READ_INIT] :
                          rinit_clr ? 1'b0 : rinit_reg;
  wire logic bufclr_next =
    (wr & is_clr) ? pwdata[flash_iap_pkg::BIT_BUF_CLEAR] :
    clear_done ? 1'b0 : bufclr_reg;
  wire logic stall_next = (op_next == flash_iap_pkg::OP_ERASE) |
                          (op_next == flash_iap_pkg::OP_WRITE) |
                          (op_next == flash_iap_pkg::OP_READ);

  always_comb
  begin
    op_next = op_state_reg;
    case (op_state_reg)
      flash_iap_pkg::OP_IDLE:
      begin
        if (start_prog)
        begin
          op_next = (mode_reg == flash_iap_pkg::MODE_ERASE) ?
                    flash_iap_pkg::OP_ERASE : flash_iap_pkg::OP_WRITE;
        end
        else if (start_read)
        begin
          op_next = flash_iap_pkg::OP_READ;
        end
        else if (start_clear)
        begin
          op_next = flash_iap_pkg::OP_CLEAR;
        end
      end
      flash_iap_pkg::OP_ERASE, flash_iap_pkg::OP_WRITE:
      begin
        if (prog_done)
        begin
          op_next = flash_iap_pkg::OP_IDLE;
        end
      end
      flash_iap_pkg::OP_READ:
      begin
        if (read_done)
        begin
          op_next = flash_iap_pkg::OP_IDLE;
        end
      end
      flash_iap_pkg::OP_CLEAR:
      begin
        if (clear_done)
        begin
          op_next = flash_iap_pkg::OP_IDLE;
        end
      end
      default:
      begin
        op_next = flash_iap_pkg::OP_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // APB answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr_reg <= psel & penable & ~pready_reg & ~mapped;
      prdata_reg <= (setup | ~pwrite) ? {24'h00_0000, rd_value}
                                      : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // Control, address and reset pattern registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enabled_reg <= 1'b0;
      mode_reg <= flash_iap_pkg::MODE_WRITE;
      trigger_reg <= 1'b0;
      winit_reg <= 1'b0;
      rden_reg <= 1'b0;
      rinit_reg <= 1'b0;
      bufclr_reg <= 1'b0;
      reset_pattern_reg <= flash_iap_pkg::BYTE_RESET;
      address_low_reg <= flash_iap_pkg::BYTE_RESET;
      address_high_reg <= flash_iap_pkg::ADDR_HIGH_RESET;
      unlock_cnt_reg <= '0;
      chip_reset_reg <= 1'b0;
    end
    else if (ce)
    begin
      enabled_reg <= enabled_next;
      trigger_reg <= trigger_next;
      winit_reg <= winit_next;
      rinit_reg <= rinit_next;
      bufclr_reg <= bufclr_next;
      if (ctrl_wr)
      begin
        mode_reg <= pwdata[flash_iap_pkg::MODE_MSB:flash_iap_pkg::MODE_LSB];
        rden_reg <= pwdata[flash_iap_pkg::BIT_READ_EN];
      end
      if (wr & is_rst)
      begin
        reset_pattern_reg <= pwdata[7:0];
      end
      chip_reset_reg <= wr & is_rst &
                        (pwdata[7:0] == flash_iap_pkg::CHIP_RESET_KEY);
      unlock_cnt_reg <= (trig_start | ~trigger_reg) ? '0 :
                        unlock_cnt_reg + 1'b1;
      if (buf_load)
      begin
        {address_high_reg, address_low_reg} <= inc_addr;
      end
      else if (wr & is_alo)
      begin
        address_low_reg <= pwdata[7:0];
      end
      else if (wr & is_ahi)
      begin
        address_high_reg <= pwdata[3:0];
      end
    end
  end

  // ==========================================================================
  // Data registers, write buffer and operation sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
      begin
        data_low_reg[i] <= flash_iap_pkg::BYTE_RESET;
        data_high_reg[i] <= flash_iap_pkg::BYTE_RESET;
      end
      tag_reg <= '0;
      op_state_reg <= flash_iap_pkg::OP_IDLE;
      op_cnt_reg <= '0;
    end
    else if (ce)
    begin
      if (read_done)
      begin
        {data_high_reg[0], data_low_reg[0]} <= flash_rdata;
      end
      else if (wr & is_data & data_hi)
      begin
        data_high_reg[data_idx] <= pwdata[7:0];
      end
      else if (wr & is_data)
      begin
        data_low_reg[data_idx] <= pwdata[7:0];
      end
      if (buf_wipe)
      begin
        tag_reg <= '0;
      end
      else if (buf_load)
      begin
        tag_reg[address_low_reg[4:0]] <= 1'b1;
      end
      op_state_reg <= op_next;
      op_cnt_reg <= (op_next != op_state_reg) ? '0 : op_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (ce && buf_load)
    begin
      buf_mem[address_low_reg[4:0]] <= {data_high_reg[0] & 8'h00 |
                                        pwdata[7:0], data_low_reg[0]};
    end
  end

  // ==========================================================================
  // Array strobes and stall
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      erase_reg <= 1'b0;
      program_reg <= 1'b0;
      read_reg <= 1'b0;
      flash_addr_reg <= 12'h000;
      flash_wdata_reg <= 16'h0000;
      stall_reg <= 1'b0;
    end
    else if (ce)
    begin
      erase_reg <= erase_pulse;
      program_reg <= prog_pulse;
      read_reg <= read_pulse;
      flash_addr_reg <= prog_pulse ? {word_addr[11:5], step} : word_addr;
      flash_wdata_reg <= prog_pulse ? buf_mem[step] : 16'h0000;
      stall_reg <= stall_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign flash_erase = erase_reg;
  assign flash_program = program_reg;
  assign flash_read = read_reg;
  assign flash_addr = flash_addr_reg;
  assign flash_wdata = flash_wdata_reg;
  assign cpu_stall = stall_reg;
  assign chip_reset = chip_reset_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_load;
    buf_load & ~buf_wipe;
  endsequence

  a_low_no_load: assert property (
    (wr & (paddr == flash_iap_pkg::OFS_DATA0_LOW) & ~buf_wipe)
      |=> $stable(tag_reg))
    else $error("low byte write changed the buffer");
  a_high_bump: assert property (
    s_load |=> (tag_reg[$past(address_low_reg[4:0])] &&
      ({address_high_reg, address_low_reg} ==
       next_word_addr($past(word_addr)))))
    else $error("high byte write did not load and step");
  a_enable_no_set: assert property (
    (ctrl_wr & ~enabled_reg & ~unlock_ok) |=> ~enabled_reg)
    else $error("software set the enable bit");
  a_enable_cause: assert property (
    $rose(enabled_reg) |-> $past(unlock_ok))
    else $error("enable set without unlock");
  a_trigger_fall: assert property (
    $fell(trigger_reg) |-> $past(expire | ctrl_wr))
    else $error("trigger dropped without cause");
  a_prog_gate: assert property (
    (idle & ~enabled_reg & ce) |=>
      (op_state_reg != flash_iap_pkg::OP_ERASE) &&
      (op_state_reg != flash_iap_pkg::OP_WRITE))
    else $error("erase or write started while locked");
  a_read_gate: assert property (
    (idle & ~rden_reg & ce) |=> (op_state_reg != flash_iap_pkg::OP_READ))
    else $error("read started while disabled");
  a_write_end: assert property (
    ((op_state_reg == flash_iap_pkg::OP_WRITE) & prog_done & ce & ~ctrl_wr)
      |=> (~winit_reg && (tag_reg == '0) && ~cpu_stall))
    else $error("write end left state behind");
  a_stall_busy: assert property (
    (~idle & (op_state_reg != flash_iap_pkg::OP_CLEAR) & ~prog_done &
     ~read_done & ce) |=> cpu_stall)
    else $error("cpu not stalled during operation");
  a_chip_reset: assert property (
    (wr & is_rst & (pwdata[7:0] == flash_iap_pkg::CHIP_RESET_KEY))
      |=> chip_reset ##1 (~chip_reset | $past(wr) | ~$past(ce)))
    else $error("reset key gave no chip reset");
  a_clear_zero: assert property (
    (pready & ~pwrite & (paddr == flash_iap_pkg::OFS_BUFFER_CLEAR_CONTROL))
      |-> (prdata[31:1] == 31'h0000_0000))
    else $error("upper clear bits not zero");
endmodule
`default_nettype wire

/* verification/flash_array_model.sv */
// Behavioural program-memory array behind the update controller
`default_nettype none
module flash_array_model (
  input wire logic pclk,
  input wire logic flash_erase,
  input wire logic flash_program,
  input wire logic flash_read,
  input wire logic [11:0] flash_addr,
  input wire logic [15:0] flash_wdata,
  output logic [15:0] flash_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [4096];
  int n_prog = 0;
  int n_read = 0;
  int hold = 0;
  initial
  begin
    flash_rdata = 16'hffff;
    foreach (mem[i]) mem[i] = 16'ha5a5;
  end
  // ==========================================================================
  // Array response
  always @(posedge pclk)
  begin
    if (flash_erase === 1'b1)
      for (int i = 0; i < 32; i++) mem[{flash_addr[11:5], 5'(i)}] <= 16'h0000;
    if (flash_program === 1'b1)
    begin
      mem[flash_addr] <= flash_wdata;
      n_prog <= n_prog + 1;
    end
    if (flash_read === 1'b1)
    begin
      flash_rdata <= mem[flash_addr];
      hold <= flash_iap_pkg::READ_CYCLES + 2;
      n_read <= n_read + 1;
    end
    else if (hold > 0)
      hold <= hold - 1;
    else
      flash_rdata <= ~flash_rdata;
  end
endmodule
`default_nettype wire

/* verification/flash_iap_program_controller_tb_top.sv */
// Testbench of the program-memory update controller
`default_nettype none
module flash_iap_program_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, flash_erase, flash_program, flash_read;
  logic cpu_stall, chip_reset;
  logic [15:0] flash_rdata, flash_wdata;
  logic [11:0] flash_addr;
  int err_count = 0, checks_done = 0, stall_cnt = 0, rst_cnt = 0;
  logic [7:0] key [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
  row_t rows [6] = '{'{8'h08, 32'h0000_00a5, 32'h0000_00a5, 0},
    '{8'h24, 32'h0000_0012, 32'h0000_0012, 0},
    '{8'h28, 32'h0000_00fe, 32'h0000_0000, 0},
    '{8'h20, 32'h0000_0080, 32'h0000_0000, 0},
    '{8'h34, 32'h0000_00ff, 32'h0000_0000, 1},
    '{8'h00, 32'h0000_00c3, 32'h0000_00c3, 0}};
  flash_iap_program_controller flash_iap_program_controller_i (.pclk, .presetn,
    .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .flash_rdata, .flash_erase, .flash_program, .flash_read, .flash_addr,
    .flash_wdata, .cpu_stall, .chip_reset);
  flash_array_model flash_array_model_i (.pclk, .flash_erase, .flash_program,
    .flash_read, .flash_addr, .flash_wdata, .flash_rdata);
  always #2 pclk = ~pclk;
  always @(posedge pclk) stall_cnt += (cpu_stall === 1'b1);
  always @(posedge pclk) rst_cnt += (chip_reset === 1'b1);
  // ==========================================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x)
    begin
      $display("Error %s expected %h seen %h", n, x, s);
      err_count++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do
    begin
      apb(0, a, 32'h0000_0000);
      n++;
    end
    while (rd[b] !== 1'b0 && n < 1500);
    chk("busy bit", {31'h0, rd[b]}, 32'h0000_0000);
  endtask
  task automatic go(input logic [31:0] c, input int b);
    apb(1, 8'h20, c);
    poll(8'h20, b);
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (30000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(0, rows[i].a, 32'h0000_0000);
      chk("reset value", rd, 32'h0000_0000);
      apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 32'h0000_0000);
      chk("readback", rd, rows[i].q);
      chk("error flag", {31'h0, er}, {31'h0, rows[i].e});
    end
    for (int p = 0; p < 2; p++)
    begin
      apb(1, 8'h20, 32'h0000_0068);
      foreach (key[k])
        apb(1, 8'h08 + 8'(4 * k), {24'h0, (k == 5 && p == 0) ? 8'h41 : key[k]});
      poll(8'h20, 3);
      chk("enabled", {31'h0, rd[7]}, 32'(p));
    end
    apb(1, 8'h20, 32'h0000_0080);
    apb(1, 8'h2c, 32'h0000_001e);
    apb(1, 8'h00, 32'h0000_0034);
    apb(1, 8'h04, 32'h0000_0012);
    apb(1, 8'h00, 32'h0000_0078);
    apb(1, 8'h04, 32'h0000_0056);
    apb(1, 8'h00, 32'h0000_0099);
    apb(0, 8'h2c, 32'h0000_0000);
    chk("address", rd, 32'h0000_001f);
    go(32'h0000_0084, 2);
    chk("control", rd, 32'h0000_0080);
    chk("word 30", flash_array_model_i.mem[30], 32'h0000_1234);
    chk("word 31", flash_array_model_i.mem[31], 32'h0000_5678);
    chk("programs", flash_array_model_i.n_prog, 32'h0000_0002);
    chk("stalled", 32'(stall_cnt > 0), 32'h0000_0001);
    go(32'h0000_0084, 2);
    chk("programs", flash_array_model_i.n_prog, 32'h0000_0002);
    go(32'h0000_00a4, 2);
    chk("programs", flash_array_model_i.n_prog, 32'h0000_0002);
    go(32'h0000_00b1, 0);
    chk("reads", flash_array_model_i.n_read, 32'h0000_0000);
    go(32'h0000_00b3, 0);
    apb(0, 8'h00, 32'h0000_0000);
    chk("read low", rd, 32'h0000_0078);
    apb(0, 8'h04, 32'h0000_0000);
    chk("read high", rd, 32'h0000_0056);
    apb(1, 8'h20, 32'h0000_0090);
    apb(1, 8'h04, 32'h0000_0000);
    go(32'h0000_0094, 2);
    go(32'h0000_00b3, 0);
    apb(0, 8'h04, 32'h0000_0000);
    chk("erased", rd, 32'h0000_0000);
    apb(0, 8'h00, 32'h0000_0000);
    chk("erased low", rd, 32'h0000_0000);
    chk("stall idle", {31'h0, cpu_stall}, 32'h0000_0000);
    apb(1, 8'h20, 32'h0000_0000);
    apb(0, 8'h20, 32'h0000_0000);
    chk("locked", rd, 32'h0000_0000);
    go(32'h0000_0004, 2);
    chk("programs", flash_array_model_i.n_prog, 32'h0000_0002);
    apb(1, 8'h28, 32'h0000_0001);
    ce <= 1'b0;
    repeat (40) @(posedge pclk);
    ce <= 1'b1;
    apb(0, 8'h28, 32'h0000_0000);
    chk("frozen clear", rd, 32'h0000_0001);
    poll(8'h28, 0);
    chk("pulses", rst_cnt, 32'h0000_0000);
    apb(1, 8'h24, 32'h0000_0055);
    repeat (3) @(posedge pclk);
    chk("chip reset", rst_cnt, 32'h0000_0001);
    wrap_up();
  end
endmodule
`default_nettype wire
